// [design/aidr_diag_record.sv]
// Top of the diagnostic record: error capture, access decode and reads
`timescale 1ns/1ns
module aidr_diag_record (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic REQ_VALID_IN,
  input wire aidr_pkg::aidr_req_s REQ_IN,
  input wire aidr_pkg::aidr_mod_flt_s MOD_FLT_IN,
  input wire aidr_pkg::aidr_ch_flt_s [3:0] CH_FLT_IN,
  output wire logic [3:0] CH_LED_OUT,
  output aidr_pkg::aidr_rsp_s RSP_OUT
);

  // ==========================================================
  // Module state
  typedef struct packed {
    logic [7:0] summary;   // Module error summary byte
    logic [7:0] internal;  // Internal fault flags byte
    logic [7:0] group;     // Channel group faults byte
    logic [31:0] snap;     // Counter copy for torn-free reads
    aidr_pkg::aidr_rsp_s rsp;  // Answer to the last request
  } aidr_top_st_s;

  localparam aidr_top_st_s RST_ST = '{
    summary: aidr_pkg::FLT_RST,
    internal: aidr_pkg::FLT_RST,
    group: aidr_pkg::FLT_RST,
    snap: aidr_pkg::TICK_RST,
    rsp: '0
  };

  aidr_top_st_s st_ff;  // Registered state
  aidr_top_st_s nxt;    // Its next value

  // ==========================================================
  // Internal signals
  logic [1:0] rst_sync_ff;   // Reset release synchroniser
  logic rst_n;               // Synchronised reset, low active
  logic [31:0] tick;         // Live microsecond count
  logic [7:0] ch_byte [4];   // Registered channel bytes
  logic [3:0] grp_hit;       // Any fault per channel, this cycle
  logic [3:0] grp_seen;      // Any fault per registered byte
  logic hit;                 // Request lands on a mapped byte
  logic [4:0] idx;           // Byte offset inside the record
  logic [7:0] rd;            // Byte at that offset
  logic is_full;             // Selector names the full record
  logic is_short;            // Selector names the first four

  // ==========================================================
  // Reset release
  // Assertion is immediate, release waits two edges so that no
  // flip-flop sees the edge of the reset near a clock edge.
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ==========================================================
  // Microsecond counter
  aidr_us_ticker u_ticker (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .count_out(tick)
  );

  // ==========================================================
  // Per-channel fault bytes and LEDs
  for (genvar n = 0; n < aidr_pkg::CH_CNT; n++) begin : g_chan
    aidr_chan_fault u_chan (
      .clk_in(CLOCK_IN),
      .rst_n_in(rst_n),
      .flt_in(CH_FLT_IN[n]),
      .byte_out(ch_byte[n]),
      .led_out(CH_LED_OUT[n])
    );
    // Same cycle as the byte capture, so group and byte align
    assign grp_hit[n] = |CH_FLT_IN[n];
    // Seen from the stored byte, used only for checking
    assign grp_seen[n] = (ch_byte[n] != aidr_pkg::FLT_RST);
  end

  // ==========================================================
  // Next state: error bytes, access decode, read mux, answer
  always_comb begin
    nxt = st_ff;
    hit = 1'b0;
    idx = aidr_pkg::OFS_SUMMARY;
    rd = aidr_pkg::FLT_RST;
    is_full = 1'b0;
    is_short = 1'b0;

    // Group byte: upper nibble reserved
    nxt.group = {4'h0, grp_hit};

    // Summary byte, reserved bits 6 and 5 held low
    nxt.summary = aidr_pkg::FLT_RST;
    nxt.summary[aidr_pkg::SUM_MOD_FAIL] = MOD_FLT_IN.mod_fail;
    nxt.summary[aidr_pkg::SUM_INT] = MOD_FLT_IN.int_err;
    nxt.summary[aidr_pkg::SUM_EXT] = MOD_FLT_IN.ext_err;
    nxt.summary[aidr_pkg::SUM_CHAN] = |grp_hit;
    nxt.summary[aidr_pkg::SUM_AUX] = MOD_FLT_IN.aux_missing;
    nxt.summary[aidr_pkg::SUM_PARAM] = MOD_FLT_IN.param_err;

    // Internal fault byte, only two live bits
    nxt.internal = aidr_pkg::FLT_RST;
    nxt.internal[aidr_pkg::INT_BUF_OVF] = MOD_FLT_IN.buf_ovf;
    nxt.internal[aidr_pkg::INT_COMM] = MOD_FLT_IN.comm_err;

    // Which byte does the request name, and is it reachable
    case (REQ_IN.mode)
      aidr_pkg::MODE_RECSET: begin
        // Record set path
        is_full = (REQ_IN.sel == aidr_pkg::REC_FULL);
        is_short = (REQ_IN.sel == aidr_pkg::REC_SHORT);
      end
      aidr_pkg::MODE_INDEX: begin
        // Object index path
        is_full = (REQ_IN.sel == aidr_pkg::INDEX_FULL);
        is_short = (REQ_IN.sel == aidr_pkg::INDEX_SHORT);
      end
      aidr_pkg::MODE_SUBIDX: begin
        // One subindex per byte; the counter has one subindex and
        // its four bytes are picked by the offset
        if (REQ_IN.sel == aidr_pkg::SUBIDX_OBJ) begin
          if (REQ_IN.sub >= aidr_pkg::SUBIDX_FIRST &&
              REQ_IN.sub <= aidr_pkg::SUBIDX_LAST &&
              REQ_IN.offs == aidr_pkg::OFS_SUMMARY) begin
            hit = 1'b1;
            idx = 5'(REQ_IN.sub - aidr_pkg::SUBIDX_FIRST);
          end else if (REQ_IN.sub == aidr_pkg::SUBIDX_TICKER &&
                       REQ_IN.offs < aidr_pkg::TICK_BYTES) begin
            hit = 1'b1;
            idx = 5'(aidr_pkg::OFS_TICKER + REQ_IN.offs);
          end
        end
      end
      default: begin
        // Unused mode code: refused
        hit = 1'b0;
      end
    endcase

    // Record paths share the length check
    if (is_full) begin
      hit = (REQ_IN.offs < aidr_pkg::FULL_LEN);
      idx = REQ_IN.offs;
    end else if (is_short) begin
      hit = (REQ_IN.offs < aidr_pkg::SHORT_LEN);
      idx = REQ_IN.offs;
    end

    // Read mux; spare offset 2 and unused offsets 12 to 15 read as zero
    case (idx)
      aidr_pkg::OFS_SUMMARY: rd = st_ff.summary;
      aidr_pkg::OFS_MODCLASS: rd = aidr_pkg::MODCLASS_INFO;
      aidr_pkg::OFS_INTERNAL: rd = st_ff.internal;
      aidr_pkg::OFS_CHAN_KIND: rd = aidr_pkg::CHAN_KIND_AI;
      aidr_pkg::OFS_BITS: rd = aidr_pkg::BITS_PER_CH;
      aidr_pkg::OFS_NUM_CH: rd = aidr_pkg::NUM_CH_BYTE;
      aidr_pkg::OFS_GROUP: rd = st_ff.group;
      aidr_pkg::OFS_TICKER: rd = tick[7:0];
      default: begin
        if (idx >= aidr_pkg::OFS_CH0 && idx < aidr_pkg::OFS_SPARE_CH) begin
          // Channel bytes 0 to 3
          rd = ch_byte[2'(idx - aidr_pkg::OFS_CH0)];
        end else if (idx > aidr_pkg::OFS_TICKER) begin
          // Upper counter bytes come from the copy taken with the
          // low byte, so a bytewise read never tears across a carry
          rd = st_ff.snap[8 * 32'(2'(idx - aidr_pkg::OFS_TICKER)) +: 8];
        end else begin
          // Spare byte and the four unused channel bytes
          rd = aidr_pkg::FLT_RST;
        end
      end
    endcase

    // Copy the counter whenever its low byte is read
    if (REQ_VALID_IN && hit && idx == aidr_pkg::OFS_TICKER) begin
      nxt.snap = tick;
    end

    // Answer strictly on request; nothing is pushed unprompted
    nxt.rsp.ack = REQ_VALID_IN;
    nxt.rsp.err = REQ_VALID_IN && !hit;
    nxt.rsp.data = (REQ_VALID_IN && hit) ? rd : aidr_pkg::FLT_RST;
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt;
    end
  end

  assign RSP_OUT = st_ff.rsp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!rst_n);

a_no_push:
  assert property (!REQ_VALID_IN |=> !RSP_OUT.ack && RSP_OUT.data == 8'h00)
    else $error("Answer given without a request");

a_rec_short:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_RECSET &&
      REQ_IN.sel == aidr_pkg::REC_SHORT &&
      REQ_IN.offs == aidr_pkg::SHORT_LEN |=> RSP_OUT.ack && RSP_OUT.err)
    else $error("Short record gave a fifth byte");

a_rec_full:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_RECSET &&
      REQ_IN.sel == aidr_pkg::REC_FULL && REQ_IN.offs == 5'h01
      |=> !RSP_OUT.err && RSP_OUT.data == aidr_pkg::MODCLASS_INFO)
    else $error("Full record module byte wrong");

a_idx_ticker:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_INDEX &&
      REQ_IN.sel == aidr_pkg::INDEX_FULL &&
      REQ_IN.offs == aidr_pkg::OFS_TICKER
      |=> !RSP_OUT.err && RSP_OUT.data == $past(tick[7:0]))
    else $error("Index read of counter low byte wrong");

a_idx_short:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_INDEX &&
      REQ_IN.sel == aidr_pkg::INDEX_SHORT &&
      REQ_IN.offs == aidr_pkg::OFS_CHAN_KIND |=> RSP_OUT.err)
    else $error("Short index gave a fifth byte");

a_sub_first:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_SUBIDX &&
      REQ_IN.sel == aidr_pkg::SUBIDX_OBJ && REQ_IN.sub == 8'h02 &&
      REQ_IN.offs == 5'h00
      |=> !RSP_OUT.err && RSP_OUT.data == $past(st_ff.summary))
    else $error("First subindex is not the summary");

a_sum_param:
  assert property (MOD_FLT_IN.param_err
      |=> st_ff.summary[aidr_pkg::SUM_PARAM] && st_ff.summary[6:5] == 2'h0)
    else $error("Parameter error missing in summary");

a_int_ovf:
  assert property (MOD_FLT_IN.buf_ovf && !MOD_FLT_IN.comm_err
      |=> st_ff.internal == 8'h08)
    else $error("Buffer overflow flag wrong");

a_kind_byte:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_SUBIDX &&
      REQ_IN.sel == aidr_pkg::SUBIDX_OBJ && REQ_IN.sub == 8'h06 &&
      REQ_IN.offs == 5'h00 |=> RSP_OUT.data == 8'h71)
    else $error("Channel type byte wrong");

a_count_byte:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_RECSET &&
      REQ_IN.sel == aidr_pkg::REC_FULL && REQ_IN.offs == 5'h06
      |=> RSP_OUT.data == 8'h04)
    else $error("Channel count byte wrong");

a_group_map:
  assert property (st_ff.group == {4'h0, grp_seen})
    else $error("Group byte and channel bytes disagree");

a_sum_chan:
  assert property (st_ff.summary[aidr_pkg::SUM_CHAN] == (st_ff.group != 8'h00))
    else $error("Summary channel bit out of step");

a_spare_zero:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_RECSET &&
      REQ_IN.sel == aidr_pkg::REC_FULL &&
      REQ_IN.offs == aidr_pkg::OFS_SPARE_CH
      |=> !RSP_OUT.err && RSP_OUT.data == 8'h00)
    else $error("Unused channel byte not zero");

a_bits_byte:
  assert property (REQ_VALID_IN &&
      REQ_IN.mode == aidr_pkg::MODE_RECSET &&
      REQ_IN.sel == aidr_pkg::REC_FULL && REQ_IN.offs == 5'h05
      |=> !RSP_OUT.err && RSP_OUT.data == 8'h08)
    else $error("Diagnostic bits byte wrong");

a_ext_sum:
  assert property (MOD_FLT_IN.ext_err && !MOD_FLT_IN.mod_fail
      |=> st_ff.summary[aidr_pkg::SUM_EXT] &&
          !st_ff.summary[aidr_pkg::SUM_MOD_FAIL])
    else $error("External error missing in summary");

// LEDs and group byte live in separate flops; they must agree
a_led_group:
  assert property (CH_LED_OUT == st_ff.group[3:0])
    else $error("Channel LEDs and group byte disagree");

endmodule : aidr_diag_record

// [inc/aidr_pkg.sv]
// Package: constants and carrier types of the analog input diagnostic record
package aidr_pkg;

  // Notes on behaviour
  // - No diagnostic interrupt; record is read only
  // - Channel error lights LED and enters record
  // - Record 01h full record, 00h first four
  // - Index 2F01h full record, 2F00h first four
  // - Index 5005h, one subindex per byte from 02h; the four counter bytes share subindex 13h, picked by offset
  // - Summary bits 0-4 and 7 flag module errors
  // - Module info byte reads 15h, analog class
  // - Internal byte: bit 3 overflow, bit 4 comms
  // - Channel type byte reads 71h, analog input
  // - Diagnostic bits per channel reads 08h
  // - Channel count byte reads 04h
  // - Group error bit n follows channel n
  // - Channel byte: param, wire, under, overflow bits
  // - Microsecond counter from zero, wraps at top

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int TICK_CYC = US_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
  localparam logic [6:0] TICK_PRE_RST = 7'h00;
  localparam logic [31:0] TICK_RST = 32'h0000_0000;

  // ==========================================================
  // Selectors of the three access paths
  localparam logic [15:0] REC_SHORT = 16'h0000;
  localparam logic [15:0] REC_FULL = 16'h0001;
  localparam logic [15:0] INDEX_SHORT = 16'h2F00;
  localparam logic [15:0] INDEX_FULL = 16'h2F01;
  localparam logic [15:0] SUBIDX_OBJ = 16'h5005;
  localparam logic [7:0] SUBIDX_FIRST = 8'h02;
  localparam logic [7:0] SUBIDX_LAST = 8'h11;
  localparam logic [7:0] SUBIDX_TICKER = 8'h13;

  // ==========================================================
  // Byte offsets inside the record
  localparam logic [4:0] OFS_SUMMARY = 5'h00;
  localparam logic [4:0] OFS_MODCLASS = 5'h01;
  localparam logic [4:0] OFS_INTERNAL = 5'h03;
  localparam logic [4:0] OFS_CHAN_KIND = 5'h04;
  localparam logic [4:0] OFS_BITS = 5'h05;
  localparam logic [4:0] OFS_NUM_CH = 5'h06;
  localparam logic [4:0] OFS_GROUP = 5'h07;
  localparam logic [4:0] OFS_CH0 = 5'h08;
  localparam logic [4:0] OFS_SPARE_CH = 5'h0C;
  localparam logic [4:0] OFS_TICKER = 5'h10;
  localparam logic [4:0] SHORT_LEN = 5'h04;
  localparam logic [4:0] FULL_LEN = 5'h14;
  localparam logic [4:0] TICK_BYTES = 5'h04;

  // ==========================================================
  // Fixed contents and reset values
  localparam int CH_CNT = 4;
  localparam logic [7:0] MODCLASS_INFO = 8'h15;
  localparam logic [7:0] CHAN_KIND_AI = 8'h71;
  localparam logic [7:0] BITS_PER_CH = 8'h08;
  localparam logic [7:0] NUM_CH_BYTE = 8'h04;
  localparam logic [7:0] FLT_RST = 8'h00;

  // ==========================================================
  // Bit positions
  localparam int SUM_MOD_FAIL = 0;
  localparam int SUM_INT = 1;
  localparam int SUM_EXT = 2;
  localparam int SUM_CHAN = 3;
  localparam int SUM_AUX = 4;
  localparam int SUM_PARAM = 7;
  localparam int INT_BUF_OVF = 3;
  localparam int INT_COMM = 4;
  localparam int CH_PARAM = 0;
  localparam int CH_WIRE = 4;
  localparam int CH_UNDER = 6;
  localparam int CH_OVER = 7;

  // ==========================================================
  // Carrier types
  typedef enum logic [1:0] {
    MODE_RECSET,
    MODE_INDEX,
    MODE_SUBIDX
  } aidr_mode_e;

  typedef struct packed {
    aidr_mode_e mode;
    logic [15:0] sel;
    logic [7:0] sub;
    logic [4:0] offs;
  } aidr_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [7:0] data;
  } aidr_rsp_s;

  typedef struct packed {
    logic mod_fail;
    logic int_err;
    logic ext_err;
    logic aux_missing;
    logic param_err;
    logic buf_ovf;
    logic comm_err;
  } aidr_mod_flt_s;

  typedef struct packed {
    logic param;
    logic wire_brk;
    logic under;
    logic over;
  } aidr_ch_flt_s;

endpackage : aidr_pkg

// [design/aidr_us_ticker.sv]
// Free-running microsecond counter of the diagnostic record
`timescale 1ns/1ns
module aidr_us_ticker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic [31:0] count_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [6:0] pre;   // Clock cycles within one microsecond
    logic [31:0] cnt;  // Microseconds since reset
  } aidr_tick_st_s;

  aidr_tick_st_s st_ff;
  aidr_tick_st_s nxt;

  // Prescaler rolls once per microsecond; counter wraps on its own
  always_comb begin
    nxt = st_ff;
    if (st_ff.pre == aidr_pkg::TICK_LAST) begin
      nxt.pre = aidr_pkg::TICK_PRE_RST;
      nxt.cnt = st_ff.cnt + 32'h0000_0001;
    end else begin
      nxt.pre = st_ff.pre + 7'h01;
    end
  end

  // Starts from zero at every reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= {aidr_pkg::TICK_PRE_RST, aidr_pkg::TICK_RST};
    end else begin
      st_ff <= nxt;
    end
  end

  assign count_out = st_ff.cnt;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

a_tick_step:
  assert property (st_ff.pre == aidr_pkg::TICK_LAST
      |=> st_ff.cnt == $past(st_ff.cnt) + 32'h0000_0001)
    else $error("Counter missed its microsecond step");

a_tick_hold:
  assert property (st_ff.pre != aidr_pkg::TICK_LAST |=> $stable(st_ff.cnt))
    else $error("Counter moved inside a microsecond");

endmodule : aidr_us_ticker

// [design/aidr_chan_fault.sv]
// One channel's fault byte and indicator LED
`timescale 1ns/1ns
module aidr_chan_fault (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire aidr_pkg::aidr_ch_flt_s flt_in,
  output logic [7:0] byte_out,
  output logic led_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] flags;  // Channel-specific error byte
    logic led;          // Channel LED drive
  } aidr_chan_st_s;

  aidr_chan_st_s st_ff;
  aidr_chan_st_s nxt;

  // Reserved bits stay at zero by starting from the reset byte
  always_comb begin
    nxt.flags = aidr_pkg::FLT_RST;
    nxt.flags[aidr_pkg::CH_PARAM] = flt_in.param;
    nxt.flags[aidr_pkg::CH_WIRE] = flt_in.wire_brk;
    nxt.flags[aidr_pkg::CH_UNDER] = flt_in.under;
    nxt.flags[aidr_pkg::CH_OVER] = flt_in.over;
    nxt.led = |flt_in;
  end

  // Byte and LED change on the same edge so they never disagree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= {aidr_pkg::FLT_RST, 1'b0};
    end else begin
      st_ff <= nxt;
    end
  end

  assign byte_out = st_ff.flags;
  assign led_out = st_ff.led;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

a_led_match:
  assert property (st_ff.led == (st_ff.flags != aidr_pkg::FLT_RST))
    else $error("LED and channel byte disagree");

a_over_bit:
  assert property (flt_in.over && !flt_in.param
      |=> st_ff.flags[aidr_pkg::CH_OVER] && !st_ff.flags[aidr_pkg::CH_PARAM])
    else $error("Overflow not entered in channel byte");

endmodule : aidr_chan_fault

// [dv/aidr_host_model.sv]
// Host-side model that issues reads of the diagnostic record
`timescale 1ns/1ns
module aidr_host_model (
  input wire logic clk_in,
  input wire aidr_pkg::aidr_rsp_s rsp_in,
  output logic valid_out,
  output aidr_pkg::aidr_req_s req_out
);
  // ==========================================================
  // Idle state of the request lines
  initial begin
    valid_out = 1'h0;
    req_out = '0;
  end

  // ==========================================================
  // One read: driven on a falling edge, taken at the next rising
  // edge; the answer stands for one cycle only, so it is sampled
  // at the falling edge inside that cycle
  task automatic rd(input aidr_pkg::aidr_req_s q,
                    output aidr_pkg::aidr_rsp_s r);
    @(negedge clk_in);
    valid_out = 1'h1;
    req_out = q;
    @(posedge clk_in);
    @(negedge clk_in);
    valid_out = 1'h0;
    // Released lines change, so a stale request cannot pass
    req_out = ~q;
    r = rsp_in;
  endtask : rd
endmodule : aidr_host_model

// [dv/testbench.sv]
// Self-checking bench of the diagnostic record
`timescale 1ns/1ns
module testbench;
  // ==========================================================
  // Signals and counters
  logic CLOCK_IN;
  logic ARST_N_IN;
  logic REQ_VALID_IN;
  aidr_pkg::aidr_req_s REQ_IN;
  aidr_pkg::aidr_mod_flt_s MOD_FLT_IN;
  aidr_pkg::aidr_ch_flt_s [3:0] CH_FLT_IN;
  logic [3:0] CH_LED_OUT;
  aidr_pkg::aidr_rsp_s RSP_OUT;
  aidr_pkg::aidr_rsp_s r;
  aidr_pkg::aidr_req_s q;
  logic [31:0] seed; // Stimulus source
  logic [31:0] cnt; // Ticker assembled from four reads
  int n_fail;
  int num_checks;
  int cyc; // Rising edges since reset release
  int t0;
  int p;
  int o;
  logic ok; // Ticker within one microsecond of the model

  aidr_diag_record u_aidr_diag_record (
    .CLOCK_IN(CLOCK_IN),
    .ARST_N_IN(ARST_N_IN),
    .REQ_VALID_IN(REQ_VALID_IN),
    .REQ_IN(REQ_IN),
    .MOD_FLT_IN(MOD_FLT_IN),
    .CH_FLT_IN(CH_FLT_IN),
    .CH_LED_OUT(CH_LED_OUT),
    .RSP_OUT(RSP_OUT)
  );

  aidr_host_model u_aidr_host_model (
    .clk_in(CLOCK_IN),
    .rsp_in(RSP_OUT),
    .valid_out(REQ_VALID_IN),
    .req_out(REQ_IN)
  );

  // 100 MHz clock
  initial begin
    CLOCK_IN = 1'h0;
    forever #5 CLOCK_IN = ~CLOCK_IN;
  end

  // Edge count and hang guard; a normal run needs about 1500
  always @(posedge CLOCK_IN) begin
    if (ARST_N_IN) cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      test_done();
    end
  end

  // ==========================================================
  // Reference model of the record
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 8; i++) s = {s[30:0], s[31]^s[21]^s[1]^s[0]};
    return s;
  endfunction : lfsr

  function automatic logic [3:0] grp();
    logic [3:0] g;
    for (int n = 0; n < 4; n++) g[n] = |CH_FLT_IN[n];
    return g;
  endfunction : grp

  function automatic logic [7:0] exp_byte(input int k);
    aidr_pkg::aidr_mod_flt_s m;
    aidr_pkg::aidr_ch_flt_s c;
    m = MOD_FLT_IN;
    c = CH_FLT_IN[k % 4];
    case (k)
      0: return {m.param_err, 2'h0, m.aux_missing, |grp(), m.ext_err,
                 m.int_err, m.mod_fail};
      1: return 8'h15;
      3: return {3'h0, m.comm_err, m.buf_ovf, 3'h0};
      4: return 8'h71;
      5: return 8'h08;
      6: return 8'h04;
      7: return {4'h0, grp()};
      8, 9, 10, 11: return {c.over, c.under, 1'h0, c.wire_brk, 3'h0,
                            c.param};
      default: return 8'h00; // Spare and unused channel bytes
    endcase
  endfunction : exp_byte

  function automatic aidr_pkg::aidr_req_s mk(input int m, input int s,
                                             input int sb, input int k);
    aidr_pkg::aidr_req_s x;
    x.mode = aidr_pkg::aidr_mode_e'(m[1:0]);
    x.sel = s[15:0];
    x.sub = sb[7:0];
    x.offs = k[4:0];
    return x;
  endfunction : mk

  // Paths 0..1 reach the whole record, 2 bytes 0 to 15 only, 3..4 the short view only
  function automatic aidr_pkg::aidr_req_s path(input int pp, input int k);
    case (pp)
      0: return mk(0, 16'h0001, 0, k);
      1: return mk(1, 16'h2F01, 0, k);
      2: return mk(2, 16'h5005, k + 2, 0);
      3: return mk(0, 16'h0000, 0, k);
      default: return mk(1, 16'h2F00, 0, k);
    endcase
  endfunction : path

  // ==========================================================
  // Compare and report
  task automatic chk(input logic [9:0] got, input logic [9:0] want,
                     input string what);
    num_checks++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, want);
    end
  endtask : chk

  task automatic rdchk(input aidr_pkg::aidr_req_s x, input logic [9:0] e);
    u_aidr_host_model.rd(x, r);
    chk(r, e, "read");
  endtask : rdchk

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // Main sequence
  initial begin
    ARST_N_IN = 1'h0;
    MOD_FLT_IN = '0;
    CH_FLT_IN = '0;
    seed = 32'h97c1_09e3;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    repeat (12) @(negedge CLOCK_IN);
    ARST_N_IN = 1'h1;
    repeat (3) @(posedge CLOCK_IN);
    // Reset contents over every full path
    for (int pp = 0; pp < 3; pp++) begin
      for (int k = 0; k < 16; k++) begin
        q = path(pp, k);
        rdchk(q, {2'h2, exp_byte(k)});
      end
    end
    $display("test reset_values done");
    // Random faults, read back by a random path
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      MOD_FLT_IN = seed[6:0] & {7{seed[31]}};
      CH_FLT_IN = seed[22:7] & {16{seed[30]}};
      seed = lfsr(seed);
      p = seed[2:0] % 5;
      o = (p > 2) ? seed[5:4] : seed[9:6];
      rdchk(path(p, o), {2'h2, exp_byte(o)});
      chk({6'h0, CH_LED_OUT}, {6'h0, grp()}, "led");
    end
    $display("test fault_bytes done");
    // Refused requests: wrong mode, selector, offset or subindex
    for (int k = 0; k < 9; k++) begin
      case (k)
        0: q = mk(0, 16'h0002, 0, 0);
        1: q = mk(0, 16'h0000, 0, 4);
        2: q = mk(1, 16'h2F00, 0, 4);
        3: q = mk(1, 16'h2F01, 0, 20);
        4: q = mk(2, 16'h5006, 2, 0);
        5: q = mk(2, 16'h5005, 8'h12, 0);
        6: q = mk(2, 16'h5005, 2, 1);
        7: q = mk(2, 16'h5005, 8'h13, 4);
        default: q = mk(3, 16'h0001, 0, 0);
      endcase
      rdchk(q, 10'h300);
    end
    $display("test refusals done");
    // Ticker: low byte first, by record set, index, then subindex
    for (int rnd = 0; rnd < 3; rnd++) begin
      repeat (400) @(negedge CLOCK_IN);
      for (int b = 0; b < 4; b++) begin
        q = (rnd == 2) ? mk(2, 16'h5005, 8'h13, b) : path(rnd, 16 + b);
        u_aidr_host_model.rd(q, r);
        if (b == 0) t0 = cyc;
        cnt[8*b +: 8] = r.data;
        chk({r.ack, r.err, 8'h00}, 10'h200, "tick ack");
      end
      t0 = (t0 - 2) / 100;
      ok = (cnt <= t0 + 1) && (cnt + 1 >= t0);
      chk({9'h0, ok}, 10'h001, "ticker");
    end
    $display("test ticker done");
    test_done();
  end
endmodule : testbench
